/* mcsa_pkg.sv */
// Shared constants for the multichip code sync engine and its controller
// Notes on behaviour
// - Master drives coded sync stream onto sync out
// - Receiver emits one pulse per recognised code
// - Sync aligns clock state and phase accumulator
// - Controller sets reg1 bits 13,12, clears 11
// - Controller sets reg3 bits 26,10; 25 master
// - Lock status reads at reg9 bit 10
// - Lock-lost bit 11 zero while lock kept
// - Clear lock-lost by writing one then zero
// - Outbound delay trim, five bits, 80 ps steps
// - Outbound polarity bit adds half-period delay
// - Inbound delay trim, five bits, 80 ps steps
// - Match level sets required code closeness
// - Controller leaves match level at sixteen
// - Isolated bad bits do not break lock
// - Alert is open-drain, active low on errors
// - Either error flag drives alert by default
// - Each error flag individually maskable
// - Error flags latch until software overwrites
// - Each pulse loads clock state preset
// - Clock state machine has 32 states
// - Receivers load phase accumulator from stream
package mcsa_pkg;
    // Device register indices
    localparam logic [7:0] MCSA_REG_MODE   = 8'h01;
    localparam logic [7:0] MCSA_REG_SYNC   = 8'h03;
    localparam logic [7:0] MCSA_REG_STATUS = 8'h09;
    // Mode register fields
    localparam int MCSA_B_CODE_ON  = 13;
    localparam int MCSA_B_MODE_SEL = 12;
    localparam int MCSA_B_PULSE_ON = 11;
    // Sync register fields
    localparam int MCSA_F_THR_LSB  = 27;
    localparam int MCSA_B_IN_EN    = 26;
    localparam int MCSA_B_OUT_EN   = 25;
    localparam int MCSA_F_IDLY_LSB = 19;
    localparam int MCSA_F_ODLY_LSB = 11;
    localparam int MCSA_B_SET_HIGH = 10;
    localparam int MCSA_B_OUT_POL  = 9;
    localparam int MCSA_F_CST_LSB  = 4;
    localparam logic [4:0] MCSA_THR_DEFAULT = 5'h10;
    localparam logic [31:0] MCSA_SYNC_RESET = 32'h8000_0000;
    // Status register fields
    localparam int MCSA_B_SYNC_IRQ_EN = 0;
    localparam int MCSA_B_DATA_IRQ_EN = 1;
    localparam int MCSA_B_SYNC_TYPE   = 4;
    localparam int MCSA_B_SYNC_ERR    = 6;
    localparam int MCSA_B_DATA_ERR    = 7;
    localparam int MCSA_B_LOCK        = 10;
    localparam int MCSA_B_LOCK_LOST   = 11;
    localparam int MCSA_B_CLR_LOST    = 12;
    // Stream framing: 32 code chips then 32 phase bits
    localparam int MCSA_CODE_LEN  = 32;
    localparam int MCSA_FRAME_LEN = 64;
    localparam logic [31:0] MCSA_CODE = 32'h3d4e_9a61;
    localparam logic [5:0] MCSA_THR_BIAS = 6'h08;
    // Controller APB map
    localparam logic [7:0] MCSA_APB_CTRL   = 8'h00;
    localparam logic [7:0] MCSA_APB_STAT   = 8'h04;
    localparam logic [7:0] MCSA_APB_RDBACK = 8'h08;
    localparam int MCSA_C_START  = 0;
    localparam int MCSA_C_MASTER = 1;
    localparam int MCSA_C_CLEAR  = 2;
    localparam int MCSA_C_POLL   = 3;
    localparam int MCSA_C_CST_LSB = 4;
    typedef enum logic [2:0] {
        MCSA_IDLE, MCSA_W_MODE, MCSA_W_SYNC, MCSA_W_CLR1, MCSA_W_CLR0, MCSA_RD, MCSA_CAP
    } mcsa_ctl_e;
endpackage

/* mcsa_if.sv */
// Link between converter sync engine and its controller
interface mcsa_if;
    // Register port into the converter
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    // Differential sync output and shared sync input line
    logic        sync_p;
    logic        sync_n;
    logic        sync_in;
    // Open-drain alert: driver value, enable, resolved line
    logic        alert_o;
    logic        alert_oe;
    logic        alert_line;

    modport dev (
        input  reg_wr, reg_rd, reg_addr, reg_wdata, sync_in, alert_line,
        output reg_rdata, sync_p, sync_n, alert_o, alert_oe
    );
    modport ctl (
        input  reg_rdata, alert_line,
        output reg_wr, reg_rd, reg_addr, reg_wdata
    );
endinterface

/* mcsa_dev.sv */
// Converter-side code sync engine with lock flags and error alert
//
// Register access over a simple read/write strobe port and the register addresses were chosen for this implementation.
module mcsa_dev
    import mcsa_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // Link to controller and other converters
    mcsa_if.dev              link,
    // Core side
    input  wire logic [31:0] nco_ftw_in,
    input  wire logic        data_err_in,
    input  wire logic        sync_err_in,
    input  wire logic        sync_err_type_in,
    output logic             init_pulse_out,
    output logic [4:0]       clk_state_out,
    output logic [31:0]      nco_phase_out,
    // Analog delay cell controls
    output logic [4:0]       sync_out_dly_out,
    output logic             sync_out_half_out,
    output logic [4:0]       sync_in_dly_out
);
    logic [31:0] mode_reg;
    logic [31:0] sync_reg;
    logic        sync_irq_en;
    logic        data_irq_en;
    logic        sync_err_flag;
    logic        data_err_flag;
    logic        sync_err_type;
    logic        locked;
    logic        lock_lost;
    logic        clr_armed;
    logic [31:0] rx_win;
    logic [5:0]  rx_pos;
    logic        cap_on;
    logic [31:0] ph_sr;
    logic [5:0]  tx_pos;
    logic [31:0] tx_snap;
    logic        tx_bit;
    logic        code_on;
    logic        det;
    logic        det_ok;
    logic        expect_now;
    logic [5:0]  need;
    logic        wr_mode;
    logic        wr_sync;
    logic        wr_stat;

    // Count agreeing chips between window and expected code
    function automatic logic [5:0] match_count(input logic [31:0] win);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < MCSA_CODE_LEN; i++) begin
            n = n + {5'h00, ~(win[i] ^ MCSA_CODE[i])};
        end
        return n;
    endfunction

    // Write strobes
    assign wr_mode = link.reg_wr && (link.reg_addr == MCSA_REG_MODE);
    assign wr_sync = link.reg_wr && (link.reg_addr == MCSA_REG_SYNC);
    assign wr_stat = link.reg_wr && (link.reg_addr == MCSA_REG_STATUS);

    // Code mode needs both mode enables, the sync input enable and pulse mode off
    assign code_on = mode_reg[MCSA_B_CODE_ON] && mode_reg[MCSA_B_MODE_SEL]
                     && !mode_reg[MCSA_B_PULSE_ON] && sync_reg[MCSA_B_IN_EN];

    // Bias keeps default level tolerant of several bad chips
    assign need = {1'b0, sync_reg[MCSA_F_THR_LSB +: 5]} + MCSA_THR_BIAS;
    assign det  = code_on && (match_count(rx_win) >= need);
    // Once locked only the expected frame slot counts, so phase bits cannot fake a code
    assign expect_now = (rx_pos == 6'(MCSA_FRAME_LEN - 1));
    assign det_ok     = det && (!locked || expect_now);

    // Mode and sync configuration registers
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            mode_reg <= 32'h0000_0000;
            sync_reg <= MCSA_SYNC_RESET;
        end else begin
            if (wr_mode) begin
                mode_reg <= link.reg_wdata;
            end
            if (wr_sync) begin
                sync_reg <= link.reg_wdata;
            end
        end
    end

    // Delay cell controls; sub-cycle shifts happen in the pad cells
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sync_out_dly_out  <= 5'h00;
            sync_out_half_out <= 1'b0;
            sync_in_dly_out   <= 5'h00;
        end else begin
            sync_out_dly_out  <= sync_reg[MCSA_F_ODLY_LSB +: 5];
            sync_out_half_out <= sync_reg[MCSA_B_OUT_POL];
            sync_in_dly_out   <= sync_reg[MCSA_F_IDLY_LSB +: 5];
        end
    end

    // Receive window, newest chip at bit 0
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rx_win <= 32'h0000_0000;
        end else begin
            rx_win <= {rx_win[30:0], link.sync_in};
        end
    end

    // Frame position after a recognised code, and phase capture
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rx_pos <= 6'h00;
            cap_on <= 1'b0;
            ph_sr  <= 32'h0000_0000;
        end else if (det_ok) begin
            rx_pos <= 6'h00;
            cap_on <= 1'b1;
        end else begin
            rx_pos <= rx_pos + 6'h01;
            if (cap_on) begin
                ph_sr <= {ph_sr[30:0], link.sync_in};
                if (rx_pos == 6'(MCSA_CODE_LEN - 1)) begin
                    cap_on <= 1'b0;
                end
            end
        end
    end

    // Lock tracking; a missed slot drops lock
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            locked <= 1'b0;
        end else if (!code_on) begin
            locked <= 1'b0;
        end else if (det_ok) begin
            locked <= 1'b1;
        end else if (locked && expect_now) begin
            locked <= 1'b0;
        end
    end

    // Lock-lost flag, cleared by a one then zero on the clear bit
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            lock_lost <= 1'b0;
            clr_armed <= 1'b0;
        end else begin
            if (wr_stat) begin
                clr_armed <= link.reg_wdata[MCSA_B_CLR_LOST];
            end
            // Set wins over a clear landing in the same cycle
            if (locked && !(det_ok || !(expect_now || !code_on))) begin
                lock_lost <= 1'b1;
            end else if (wr_stat && clr_armed && !link.reg_wdata[MCSA_B_CLR_LOST]) begin
                lock_lost <= 1'b0;
            end
        end
    end

    // Clock generation state: 32 states, preset loaded on each pulse
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            clk_state_out <= 5'h00;
        end else if (det_ok) begin
            clk_state_out <= {1'b0, sync_reg[MCSA_F_CST_LSB +: 4]};
        end else begin
            clk_state_out <= clk_state_out + 5'h01;
        end
    end

    // Phase accumulator; every receiver loads the same word on the same edge
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            nco_phase_out <= 32'h0000_0000;
        end else if (cap_on && !det_ok && rx_pos == 6'(MCSA_CODE_LEN - 1)) begin
            nco_phase_out <= {ph_sr[30:0], link.sync_in};
        end else begin
            nco_phase_out <= nco_phase_out + nco_ftw_in;
        end
    end

    // One-cycle initialization pulse
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            init_pulse_out <= 1'b0;
        end else begin
            init_pulse_out <= det_ok;
        end
    end

    // Master transmitter: code chips then snapshot of phase, MSB first
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            tx_pos  <= 6'h00;
            tx_snap <= 32'h0000_0000;
            tx_bit  <= 1'b0;
        end else begin
            tx_pos <= tx_pos + 6'h01;
            if (tx_pos == 6'(MCSA_CODE_LEN - 1)) begin
                tx_snap <= nco_phase_out;
            end
            if (!sync_reg[MCSA_B_OUT_EN] || !code_on) begin
                tx_bit <= 1'b0;
            end else if (tx_pos < 6'(MCSA_CODE_LEN)) begin
                tx_bit <= MCSA_CODE[5'(MCSA_CODE_LEN - 1) - tx_pos[4:0]];
            end else begin
                tx_bit <= tx_snap[5'(MCSA_CODE_LEN - 1) - tx_pos[4:0]];
            end
        end
    end

    assign link.sync_p = tx_bit;
    assign link.sync_n = ~tx_bit;

    // Latched error flags and their enables; write one clears, set wins
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sync_irq_en   <= 1'b1;
            data_irq_en   <= 1'b1;
            sync_err_flag <= 1'b0;
            data_err_flag <= 1'b0;
            sync_err_type <= 1'b0;
        end else begin
            if (wr_stat) begin
                sync_irq_en <= link.reg_wdata[MCSA_B_SYNC_IRQ_EN];
                data_irq_en <= link.reg_wdata[MCSA_B_DATA_IRQ_EN];
            end
            if (sync_err_in) begin
                sync_err_flag <= 1'b1;
                sync_err_type <= sync_err_type_in;
            end else if (wr_stat && link.reg_wdata[MCSA_B_SYNC_ERR]) begin
                sync_err_flag <= 1'b0;
            end
            if (data_err_in) begin
                data_err_flag <= 1'b1;
            end else if (wr_stat && link.reg_wdata[MCSA_B_DATA_ERR]) begin
                data_err_flag <= 1'b0;
            end
        end
    end

    // Alert pulls low only; external pull-up gives the high level
    assign link.alert_o  = 1'b0;
    assign link.alert_oe = (sync_err_flag && sync_irq_en)
                           || (data_err_flag && data_irq_en);

    // Read data, one cycle after the read strobe
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            link.reg_rdata <= 32'h0000_0000;
        end else if (link.reg_rd) begin
            case (link.reg_addr)
                MCSA_REG_MODE: begin
                    link.reg_rdata <= mode_reg;
                end
                MCSA_REG_SYNC: begin
                    link.reg_rdata <= sync_reg;
                end
                MCSA_REG_STATUS: begin
                    link.reg_rdata <= 32'h0000_0000;
                    link.reg_rdata[MCSA_B_SYNC_IRQ_EN] <= sync_irq_en;
                    link.reg_rdata[MCSA_B_DATA_IRQ_EN] <= data_irq_en;
                    link.reg_rdata[MCSA_B_SYNC_TYPE]   <= sync_err_type;
                    link.reg_rdata[MCSA_B_SYNC_ERR]    <= sync_err_flag;
                    link.reg_rdata[MCSA_B_DATA_ERR]    <= data_err_flag;
                    link.reg_rdata[MCSA_B_LOCK]        <= locked;
                    link.reg_rdata[MCSA_B_LOCK_LOST]   <= lock_lost;
                    link.reg_rdata[MCSA_B_CLR_LOST]    <= clr_armed;
                end
                default: begin
                    link.reg_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end
endmodule

/* mcsa_ctl.sv */
// Controller that programs a converter for code sync, reached over APB
module mcsa_ctl
    import mcsa_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter side
    mcsa_if.ctl              link
);
    mcsa_ctl_e   state;
    logic        is_master;
    logic [3:0]  cst_preset;
    logic        go_cfg;
    logic        go_clr;
    logic        go_poll;
    logic [31:0] rdback;
    logic        apb_wr;
    logic        apb_rd;
    logic        mapped;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign mapped = (paddr == MCSA_APB_CTRL) || (paddr == MCSA_APB_STAT)
                    || (paddr == MCSA_APB_RDBACK);
    // Zero wait states; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Command capture; commands only taken while idle
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            is_master  <= 1'b0;
            cst_preset <= 4'h0;
            go_cfg     <= 1'b0;
            go_clr     <= 1'b0;
            go_poll    <= 1'b0;
        end else if (apb_wr && paddr == MCSA_APB_CTRL && state == MCSA_IDLE) begin
            is_master  <= pwdata[MCSA_C_MASTER];
            cst_preset <= pwdata[MCSA_C_CST_LSB +: 4];
            go_cfg     <= pwdata[MCSA_C_START];
            go_clr     <= pwdata[MCSA_C_CLEAR];
            go_poll    <= pwdata[MCSA_C_POLL];
        end else if (state != MCSA_IDLE) begin
            go_cfg  <= 1'b0;
            go_clr  <= 1'b0;
            go_poll <= 1'b0;
        end
    end

    // Sequencer: mode, sync setup, lock-lost clear, status read
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state <= MCSA_IDLE;
        end else begin
            case (state)
                MCSA_IDLE: begin
                    if (go_cfg) begin
                        state <= MCSA_W_MODE;
                    end else if (go_clr) begin
                        state <= MCSA_W_CLR1;
                    end else if (go_poll) begin
                        state <= MCSA_RD;
                    end
                end
                MCSA_W_MODE: state <= MCSA_W_SYNC;
                MCSA_W_SYNC: state <= MCSA_W_CLR1;
                MCSA_W_CLR1: state <= MCSA_W_CLR0;
                MCSA_W_CLR0: state <= MCSA_RD;
                MCSA_RD:     state <= MCSA_CAP;
                MCSA_CAP:    state <= MCSA_IDLE;
                default:     state <= MCSA_IDLE;
            endcase
        end
    end

    // Register port drive, one access in each state from MCSA_W_MODE to MCSA_RD, none in idle or capture
    always_comb begin
        link.reg_wr    = 1'b0;
        link.reg_rd    = 1'b0;
        link.reg_addr  = 8'h00;
        link.reg_wdata = 32'h0000_0000;
        case (state)
            MCSA_W_MODE: begin
                link.reg_wr   = 1'b1;
                link.reg_addr = MCSA_REG_MODE;
                link.reg_wdata[MCSA_B_CODE_ON]  = 1'b1;
                link.reg_wdata[MCSA_B_MODE_SEL] = 1'b1;
            end
            MCSA_W_SYNC: begin
                link.reg_wr   = 1'b1;
                link.reg_addr = MCSA_REG_SYNC;
                link.reg_wdata[MCSA_F_THR_LSB +: 5] = MCSA_THR_DEFAULT;
                link.reg_wdata[MCSA_B_IN_EN]        = 1'b1;
                link.reg_wdata[MCSA_B_OUT_EN]       = is_master;
                link.reg_wdata[MCSA_B_SET_HIGH]     = 1'b1;
                link.reg_wdata[MCSA_F_CST_LSB +: 4] = cst_preset;
            end
            MCSA_W_CLR1, MCSA_W_CLR0: begin
                link.reg_wr   = 1'b1;
                link.reg_addr = MCSA_REG_STATUS;
                link.reg_wdata[MCSA_B_SYNC_IRQ_EN] = 1'b1;
                link.reg_wdata[MCSA_B_DATA_IRQ_EN] = 1'b1;
                link.reg_wdata[MCSA_B_CLR_LOST]    = (state == MCSA_W_CLR1);
            end
            MCSA_RD: begin
                link.reg_rd   = 1'b1;
                link.reg_addr = MCSA_REG_STATUS;
            end
            default: begin
                link.reg_wr = 1'b0;
            end
        endcase
    end

    // Status word captured from the converter
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rdback <= 32'h0000_0000;
        end else if (state == MCSA_CAP) begin
            rdback <= link.reg_rdata;
        end
    end

    // APB read data
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_rd && paddr == MCSA_APB_STAT) begin
            prdata = {27'h0, !link.alert_line, rdback[MCSA_B_LOCK_LOST],
                      rdback[MCSA_B_LOCK], (state != MCSA_IDLE), is_master};
        end else if (apb_rd && paddr == MCSA_APB_RDBACK) begin
            prdata = rdback;
        end else if (apb_rd && paddr == MCSA_APB_CTRL) begin
            prdata = {24'h0, cst_preset, 3'h0, is_master};
        end
    end
endmodule

/* mcsa_chk_sva.sv */
// Checker for the register and sync signals of one converter link
module mcsa_chk
    import mcsa_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // Link signals
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        sync_p,
    input  wire logic        sync_n,
    input  wire logic        alert_o,
    input  wire logic        alert_oe
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    diff_pair_a: assert property (sync_n == !sync_p)
        else $error("sync pair not complementary");
    alert_drive_a: assert property (alert_oe |-> alert_o == 1'b0)
        else $error("alert drives high");
    alert_hold_a: assert property ($rose(alert_oe) |=> alert_oe [*8])
        else $error("alert released without overwrite");
    mode_word_a: assert property (reg_wr && reg_addr == MCSA_REG_MODE |->
        reg_wdata[MCSA_B_CODE_ON] && reg_wdata[MCSA_B_MODE_SEL] && !reg_wdata[MCSA_B_PULSE_ON])
        else $error("mode word wrong");
    mode_order_a: assert property (reg_wr && reg_addr == MCSA_REG_MODE |=>
        reg_wr && reg_addr == MCSA_REG_SYNC)
        else $error("sync word not after mode word");
    sync_word_a: assert property (reg_wr && reg_addr == MCSA_REG_SYNC |->
        reg_wdata[MCSA_B_IN_EN] && reg_wdata[MCSA_B_SET_HIGH])
        else $error("sync word enables missing");
    thr_default_a: assert property (reg_wr && reg_addr == MCSA_REG_SYNC |->
        reg_wdata[31:27] == MCSA_THR_DEFAULT)
        else $error("match level not default");
    clear_seq_a: assert property (reg_wr && reg_addr == MCSA_REG_STATUS
        && reg_wdata[MCSA_B_CLR_LOST] |=> reg_wr && reg_addr == MCSA_REG_STATUS
        && !reg_wdata[MCSA_B_CLR_LOST])
        else $error("clear one not followed by zero");
    strobe_excl_a: assert property (reg_rd |-> !reg_wr)
        else $error("read and write together");
endmodule

/* testbench.sv */
// Bench: master and slave converter pairs sharing one sync line and alert line
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module testbench;
    import mcsa_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [1:0]  psel = '0, penable = '0, pwrite = '0, derr = '0, serr = '0, fault = '0;
    logic [7:0]  paddr [2] = '{default: 8'h0};
    logic [31:0] pwdata [2] = '{default: 32'h0};
    wire  [31:0] prdata [2];
    wire  [1:0]  pready, pslverr;
    wire         ipls [2];
    wire  [4:0]  cst [2];
    wire  [31:0] ph [2];
    logic [31:0] ftw = 32'h0, seed = 32'h6378, rd;
    logic [3:0]  pre = 4'h0;
    logic        err;
    int          errors = 0, total_checks = 0, cyc = 0, n;
    mcsa_if lk [2] ();

    // Master loops its stream back; slave copy may be inverted or held low
    assign lk[0].sync_in = lk[0].sync_p;
    assign lk[1].sync_in = fault[1] ? 1'b0 : lk[0].sync_p ^ fault[0];
    // Wire-OR alert with pull-up, so either device pulls both views low
    assign lk[0].alert_line = !(lk[0].alert_oe | lk[1].alert_oe);
    assign lk[1].alert_line = lk[0].alert_line;

    for (genvar i = 0; i < 2; i++) begin : g
        mcsa_ctl mcsa_ctl_i (.clock_in(clock_in), .nrst_in(nrst_in), .psel(psel[i]),
            .penable(penable[i]), .pwrite(pwrite[i]), .paddr(paddr[i]), .pwdata(pwdata[i]),
            .prdata(prdata[i]), .pready(pready[i]), .pslverr(pslverr[i]), .link(lk[i]));
        mcsa_dev mcsa_dev_i (.clock_in(clock_in), .nrst_in(nrst_in), .link(lk[i]),
            .nco_ftw_in(ftw), .data_err_in(derr[i]), .sync_err_in(serr[i]),
            .sync_err_type_in(1'b0), .init_pulse_out(ipls[i]), .clk_state_out(cst[i]),
            .nco_phase_out(ph[i]), .sync_out_dly_out(), .sync_out_half_out(),
            .sync_in_dly_out());
    end
    mcsa_chk mcsa_chk_i (.clock_in(clock_in), .nrst_in(nrst_in), .reg_wr(lk[0].reg_wr),
        .reg_rd(lk[0].reg_rd), .reg_addr(lk[0].reg_addr), .reg_wdata(lk[0].reg_wdata),
        .sync_p(lk[0].sync_p), .sync_n(lk[0].sync_n), .alert_o(lk[0].alert_o),
        .alert_oe(lk[0].alert_oe));

    always #5 clock_in = ~clock_in;
    // Cycle ceiling: the run needs a few thousand cycles at most
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction
    // Control word: preset in [7:4], master bit only for pair 0
    function automatic logic [31:0] cw(input int i);
        return {24'h0, pre, 2'b00, i == 0, 1'b0};
    endfunction
    // APB transfer; data taken at the negedge before the edge that samples pready
    task automatic apb(input int i, input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel[i]    <= 1'b1;
        penable[i] <= 1'b0;
        pwrite[i]  <= w;
        paddr[i]   <= a;
        pwdata[i]  <= d;
        @(posedge clock_in);
        penable[i] <= 1'b1;
        @(negedge clock_in);
        while (pready[i] !== 1'b1) begin
            @(posedge clock_in);
            @(negedge clock_in);
        end
        rd  = prdata[i];
        err = pslverr[i];
        @(posedge clock_in);
        psel[i]    <= 1'b0;
        penable[i] <= 1'b0;
    endtask
    // Read status until the controller is no longer busy
    task automatic idle(input int i);
        n = 0;
        do begin
            apb(i, 1'b0, MCSA_APB_STAT, 32'h0);
            n++;
        end while (rd[1] !== 1'b0 && n < 100);
    endtask
    // Refresh the device snapshot, then compare the low status bits
    task automatic stat(input int i, input logic [4:0] e, input string s);
        apb(i, 1'b1, MCSA_APB_CTRL, cw(i) | 32'h8);
        idle(i);
        `CHK(s, e, rd[4:0])
    endtask
    task automatic finish_test();
        $display("Checks made %0d, mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_in);
        nrst_in <= 1'b1;
        // Reset status and an unmapped access
        apb(0, 1'b0, MCSA_APB_STAT, 32'h0);
        `CHK("reset status", 5'h00, rd[4:0])
        apb(1, 1'b0, 8'h0c, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        $display("Test reset done");
        // Configure slave then master with a random preset and increment
        seed = lfsr(seed);
        pre  = seed[3:0];
        ftw  <= lfsr(seed);
        apb(1, 1'b1, MCSA_APB_CTRL, cw(1) | 32'h1);
        idle(1);
        apb(0, 1'b1, MCSA_APB_CTRL, cw(0) | 32'h1);
        idle(0);
        repeat (384) @(posedge clock_in);
        stat(0, 5'h05, "master lock");
        stat(1, 5'h04, "slave lock");
        $display("Test lock done");
        // Pulses coincide and realign state and phase every frame
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while (ipls[1] !== 1'b1 && n < 200);
        `CHK("pulse pair", 1'b1, ipls[0])
        `CHK("state preset", {1'b0, pre}, cst[1])
        `CHK("state align", cst[0], cst[1])
        repeat (64) @(negedge clock_in);
        `CHK("pulse period", 1'b1, ipls[1])
        `CHK("state wrap", {1'b0, pre}, cst[1])
        `CHK("phase align", ph[0], ph[1])
        $display("Test align done");
        // One corrupted chip is tolerated
        @(posedge clock_in);
        fault <= 2'b01;
        @(posedge clock_in);
        fault <= 2'b00;
        repeat (192) @(posedge clock_in);
        stat(1, 5'h04, "single chip error");
        // Held-low input drops lock; lost flag stays until the clear sequence
        fault <= 2'b10;
        repeat (128) @(posedge clock_in);
        stat(1, 5'h08, "lock dropped");
        fault <= 2'b00;
        repeat (384) @(posedge clock_in);
        stat(1, 5'h0c, "relock keeps lost");
        apb(1, 1'b1, MCSA_APB_CTRL, cw(1) | 32'h4);
        idle(1);
        stat(1, 5'h04, "lost cleared");
        $display("Test lock lost done");
        // Error events pull the shared alert low and stay latched
        derr <= 2'b10;
        serr <= 2'b01;
        @(posedge clock_in);
        derr <= 2'b00;
        serr <= 2'b00;
        repeat (20) @(posedge clock_in);
        `CHK("alert line", 1'b0, lk[0].alert_line)
        stat(0, 5'h15, "alert latched");
        $display("Test alert done");
        finish_test();
    end
endmodule
